/* hdl/dgc_defs.svh */
// Offsets, field positions, reset values and spread-spectrum settings of the general configuration bank.
// Assumes inclusion by bare name from the package only.
`ifndef DGC_DEFS_SVH
`define DGC_DEFS_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DGC_OFS_CONFIG_ZERO    8'h02
`define DGC_OFS_CONFIG_ONE     8'h03
`define DGC_OFS_SER_ADDR       8'h06
`define DGC_OFS_REMOTE_SERIALIZER_ALIAS      8'h07
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DGC_SSC_MSB            3
`define DGC_SSC_LSB            0
`define DGC_BIT_PARITY_EN      7
`define DGC_BIT_CRC_EN         6
`define DGC_BIT_IO_AUTO        5
`define DGC_BIT_IO_LEVEL       4
`define DGC_BIT_PASS_THRU      3
`define DGC_BIT_AUTO_ACK       2
`define DGC_BIT_PAR_ERR_RST    1
`define DGC_BIT_EDGE_SEL       0
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DGC_RST_CONFIG_ZERO    8'h00
`define DGC_RST_CONFIG_ONE     8'he9
`define DGC_RST_SER_ADDR       8'h00
`define DGC_RST_REMOTE_SERIALIZER_ALIAS      8'h00
`define DGC_SSC_OFF            4'h0
// ----------------------------------------------------------------
// Spread-spectrum divisors and deviations, deviation in hundredths of percent
// ----------------------------------------------------------------
`define DGC_DIV_A              12'h878
`define DGC_DIV_B              12'h514
`define DGC_DIV_C              12'h364
`define DGC_DIV_D              12'h28a
`define DGC_DEV_050            8'h32
`define DGC_DEV_100            8'h64
`define DGC_DEV_150            8'h96
`define DGC_DEV_200            8'hc8
`endif

/* hdl/dgc_pkg.sv */
// Types shared by the general configuration bank.
// Assumes the defs header is on the include path.
package dgc_pkg;
  `include "dgc_defs.svh"
  typedef logic [7:0] dgc_byte_t;
  typedef logic [3:0] dgc_ssc_code_t;
  typedef enum logic [1:0] {
    DGC_WR_IDLE,
    DGC_WR_DATA
  } dgc_wr_state_t;
endpackage

/* hdl/dgc_ssc_decode.sv */
// Spread-spectrum select code to modulation divisor and deviation decode.
// Assumes the select code is a registered value.
`timescale 1ns/1ps
module dgc_ssc_decode
  import dgc_pkg::*;
(
  // Code in
  input  wire dgc_pkg::dgc_ssc_code_t i_code,
  // Decoded settings
  output logic                        o_enable,
  output logic [11:0]                 o_divisor,
  output logic [7:0]                  o_deviation
);
  import dgc_pkg::*;
  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Duplicate printed entries are resolved as four deviations per rate, three for the last rate, rising by code.
  always_comb begin
    o_enable = (i_code != `DGC_SSC_OFF);
    o_divisor = 12'h000;
    o_deviation = 8'h00;
    if (i_code == `DGC_SSC_OFF) begin
      o_divisor = 12'h000;
    end else if (i_code <= 4'h4) begin
      o_divisor = `DGC_DIV_A;
    end else if (i_code <= 4'h8) begin
      o_divisor = `DGC_DIV_B;
    end else if (i_code <= 4'hc) begin
      o_divisor = `DGC_DIV_C;
    end else begin
      o_divisor = `DGC_DIV_D;
    end
    if (i_code != `DGC_SSC_OFF) begin
      case ((i_code - 4'h1) & 4'h3)
        4'h0: o_deviation = `DGC_DEV_050;
        4'h1: o_deviation = `DGC_DEV_100;
        4'h2: o_deviation = `DGC_DEV_150;
        default: o_deviation = `DGC_DEV_200;
      endcase
    end
  end
endmodule

/* hdl/dgc_general_config.sv */
// General configuration register bank of the deserializer, with pass-through steering.
// Assumes a local I2C slave front end hands over decoded byte writes and reads.
// How it works
// - Select code zero turns spread-spectrum off and is the reset value.
// - Codes one to twelve pick divisors 2168, 1300, 868 in groups of four deviations.
// - Codes thirteen to fifteen pick divisor 650 with deviations from 0.50 percent up.
// - Bit 7 of the second register enables the parity checker and resets to one.
// - Bit 6 of the second register enables back-channel CRC and resets to one.
// - Bit 5 picks supply auto-detect, else bit 4 gives the level; bit 5 resets to one.
// - Bit 3 enables forwarding of remote alias transactions and resets to one.
// - Bit 2 acknowledges remote serializer writes at once; they are remapped whatever its value.
// - Bit 1 holds the parity error state in reset until software writes it to zero.
// - Bit 0 picks the rising output strobe edge when one, falling when zero.
// - The serializer address register is the remap target; zero blocks remote access.
// - The serializer alias register is matched against the transaction address here; zero blocks that path.
`timescale 1ns/1ps
module dgc_general_config
  import dgc_pkg::*;
#(
  parameter int ERR_WIDTH = 8
) (
  // Clock and reset
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_reset,
  // Register access from the I2C slave
  input  wire logic                   i_reg_wr,
  input  wire logic                   i_reg_rd,
  input  wire dgc_pkg::dgc_byte_t     i_reg_addr,
  input  wire dgc_pkg::dgc_byte_t     i_reg_wdata,
  output dgc_pkg::dgc_byte_t          o_reg_rdata,
  output logic                        o_reg_rvalid,
  // Decoded local transaction
  input  wire logic                   i_txn_start,
  input  wire logic [6:0]             i_txn_addr,
  input  wire logic                   i_txn_write,
  input  wire logic                   i_slave_alias_hit,
  output logic                        o_fwd,
  output logic [6:0]                  o_fwd_addr,
  output logic                        o_early_ack,
  // Parity events
  input  wire logic                   i_parity_err,
  output logic [ERR_WIDTH-1:0]        o_parity_err_count,
  output logic                        o_parity_err_flag,
  // Configuration outputs
  output logic                        o_ssc_enable,
  output logic [11:0]                 o_ssc_divisor,
  output logic [7:0]                  o_ssc_deviation,
  output logic                        o_parity_check_en,
  output logic                        o_crc_gen_en,
  output logic                        o_io_supply_autodetect,
  output logic                        o_io_supply_level,
  output logic                        o_output_edge_select
);
  import dgc_pkg::*;

  initial begin
    if (ERR_WIDTH < 1 || ERR_WIDTH > 16) begin
      $error("ERR_WIDTH must be 1 to 16");
    end
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  dgc_byte_t             config_zero_reg, config_zero_next;
  dgc_byte_t             config_one_reg, config_one_next;
  dgc_byte_t             ser_addr_reg, ser_addr_next;
  dgc_byte_t             remote_serializer_alias_reg, remote_serializer_alias_next;
  dgc_byte_t             rdata_reg, rdata_next;
  logic                  rvalid_reg, rvalid_next;
  logic                  fwd_reg, fwd_next;
  logic [6:0]            fwd_addr_reg, fwd_addr_next;
  logic                  early_ack_reg, early_ack_next;
  logic [ERR_WIDTH-1:0]  err_count_reg, err_count_next;
  logic                  err_flag_reg, err_flag_next;
  logic                  ssc_en_reg;
  logic [11:0]           ssc_div_reg;
  logic [7:0]            ssc_dev_reg;
  logic                  ssc_en_w;
  logic [11:0]           ssc_div_w;
  logic [7:0]            ssc_dev_w;
  logic                  par_en;
  logic                  ser_hit;

  // ----------------------------------------------------------------
  // Register writes and reads
  // ----------------------------------------------------------------
  // A read of an unmapped offset returns zero; other map registers live elsewhere.
  always_comb begin
    config_zero_next = config_zero_reg;
    config_one_next = config_one_reg;
    ser_addr_next = ser_addr_reg;
    remote_serializer_alias_next = remote_serializer_alias_reg;
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    if (i_reg_wr) begin
      if (i_reg_addr == `DGC_OFS_CONFIG_ZERO) begin
        // Upper bits of this register belong to other clock options and are written with the rest of the byte.
        config_zero_next = i_reg_wdata;
      end else if (i_reg_addr == `DGC_OFS_CONFIG_ONE) begin
        config_one_next = i_reg_wdata;
      end else if (i_reg_addr == `DGC_OFS_SER_ADDR) begin
        ser_addr_next = i_reg_wdata;
      end else if (i_reg_addr == `DGC_OFS_REMOTE_SERIALIZER_ALIAS) begin
        remote_serializer_alias_next = {i_reg_wdata[7:1], 1'b0};
      end
    end
    if (i_reg_rd) begin
      rvalid_next = 1'b1;
      if (i_reg_addr == `DGC_OFS_CONFIG_ZERO) begin
        rdata_next = config_zero_reg;
      end else if (i_reg_addr == `DGC_OFS_CONFIG_ONE) begin
        rdata_next = config_one_reg;
      end else if (i_reg_addr == `DGC_OFS_SER_ADDR) begin
        rdata_next = ser_addr_reg;
      end else if (i_reg_addr == `DGC_OFS_REMOTE_SERIALIZER_ALIAS) begin
        rdata_next = remote_serializer_alias_reg;
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      config_zero_reg <= `DGC_RST_CONFIG_ZERO;
      config_one_reg  <= `DGC_RST_CONFIG_ONE;
      ser_addr_reg    <= `DGC_RST_SER_ADDR;
      remote_serializer_alias_reg   <= `DGC_RST_REMOTE_SERIALIZER_ALIAS;
      rdata_reg       <= 8'h00;
      rvalid_reg      <= 1'b0;
    end else begin
      config_zero_reg <= config_zero_next;
      config_one_reg  <= config_one_next;
      ser_addr_reg    <= ser_addr_next;
      remote_serializer_alias_reg   <= remote_serializer_alias_next;
      rdata_reg       <= rdata_next;
      rvalid_reg      <= rvalid_next;
    end
  end

  // ----------------------------------------------------------------
  // Spread-spectrum decode
  // ----------------------------------------------------------------
  // The off-first write order is left to software; the decode follows any code at once.
  dgc_ssc_decode u_ssc (
    .i_code      (config_zero_reg[`DGC_SSC_MSB:`DGC_SSC_LSB]),
    .o_enable    (ssc_en_w),
    .o_divisor   (ssc_div_w),
    .o_deviation (ssc_dev_w)
  );

  // ----------------------------------------------------------------
  // Pass-through steering
  // ----------------------------------------------------------------
  assign ser_hit = (remote_serializer_alias_reg[7:1] != 7'h00) && (i_txn_addr == remote_serializer_alias_reg[7:1]);

  always_comb begin
    fwd_next = 1'b0;
    fwd_addr_next = fwd_addr_reg;
    early_ack_next = 1'b0;
    if (i_txn_start && config_one_reg[`DGC_BIT_PASS_THRU]) begin
      if (ser_hit && ser_addr_reg[7:1] != 7'h00) begin
        fwd_next = 1'b1;
        fwd_addr_next = ser_addr_reg[7:1];
        early_ack_next = i_txn_write && config_one_reg[`DGC_BIT_AUTO_ACK];
      end else if (i_slave_alias_hit) begin
        fwd_next = 1'b1;
        fwd_addr_next = i_txn_addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Parity error accumulation
  // ----------------------------------------------------------------
  assign par_en = config_one_reg[`DGC_BIT_PARITY_EN];

  always_comb begin
    err_count_next = err_count_reg;
    err_flag_next = err_flag_reg;
    if (config_one_reg[`DGC_BIT_PAR_ERR_RST]) begin
      err_count_next = '0;
      err_flag_next = 1'b0;
    end else if (!par_en) begin
      err_flag_next = 1'b0;
    end else if (i_parity_err) begin
      err_flag_next = 1'b1;
      // Saturates so a stuck link cannot wrap the count back to a clean value.
      if (err_count_reg != {ERR_WIDTH{1'b1}}) begin
        err_count_next = err_count_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      fwd_reg       <= 1'b0;
      fwd_addr_reg  <= 7'h00;
      early_ack_reg <= 1'b0;
      err_count_reg <= '0;
      err_flag_reg  <= 1'b0;
      ssc_en_reg    <= 1'b0;
      ssc_div_reg   <= 12'h000;
      ssc_dev_reg   <= 8'h00;
    end else begin
      fwd_reg       <= fwd_next;
      fwd_addr_reg  <= fwd_addr_next;
      early_ack_reg <= early_ack_next;
      err_count_reg <= err_count_next;
      err_flag_reg  <= err_flag_next;
      ssc_en_reg    <= ssc_en_w;
      ssc_div_reg   <= ssc_div_w;
      ssc_dev_reg   <= ssc_dev_w;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_reg_rdata            = rdata_reg;
  assign o_reg_rvalid           = rvalid_reg;
  assign o_fwd                  = fwd_reg;
  assign o_fwd_addr             = fwd_addr_reg;
  assign o_early_ack            = early_ack_reg;
  assign o_parity_err_count     = par_en ? err_count_reg : '0;
  assign o_parity_err_flag      = err_flag_reg;
  assign o_ssc_enable           = ssc_en_reg;
  assign o_ssc_divisor          = ssc_div_reg;
  assign o_ssc_deviation        = ssc_dev_reg;
  assign o_parity_check_en      = config_one_reg[`DGC_BIT_PARITY_EN];
  assign o_crc_gen_en           = config_one_reg[`DGC_BIT_CRC_EN];
  assign o_io_supply_autodetect = config_one_reg[`DGC_BIT_IO_AUTO];
  assign o_io_supply_level      = config_one_reg[`DGC_BIT_IO_LEVEL];
  assign o_output_edge_select   = config_one_reg[`DGC_BIT_EDGE_SEL];
endmodule

/* tb/dgc_host_model.sv */
// Local control-port host that issues byte writes and reads to the bank.
// Assumes the bench pulses i_go for one cycle and then waits at least four cycles.
`timescale 1ns/1ps
module dgc_host_model
  import dgc_pkg::*;
(
  // Clock and bench requests
  input  wire logic                i_sys_clk,
  input  wire logic                i_go,
  input  wire logic                i_we,
  input  wire dgc_pkg::dgc_byte_t  i_addr,
  input  wire dgc_pkg::dgc_byte_t  i_wdata,
  // Register port of the bank
  output logic                     o_reg_wr,
  output logic                     o_reg_rd,
  output dgc_pkg::dgc_byte_t       o_reg_addr,
  output dgc_pkg::dgc_byte_t       o_reg_wdata
);
  // ----------------
  // Request engine
  // ----------------
  logic      pend = 1'b0;
  dgc_byte_t held = 8'h00;
  initial begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 8'h00;
    o_reg_wdata = 8'h00;
  end
  always @(posedge i_sys_clk) begin
    o_reg_wr <= pend | (i_go & i_we);
    o_reg_rd <= i_go & ~i_we & ~pend;
    pend <= 1'b0;
    if (pend) begin
      o_reg_addr <= 8'h02;
      o_reg_wdata <= held;
    end else if (i_go) begin
      o_reg_addr <= i_addr;
      o_reg_wdata <= i_wdata;
      // The modulator never jumps between two live settings.
      if (i_we && i_addr == 8'h02 && i_wdata[3:0] != 4'h0) begin
        o_reg_wdata <= {i_wdata[7:4], 4'h0};
        held <= i_wdata;
        pend <= 1'b1;
      end
    end
  end
endmodule

/* tb/dgc_general_config_chk.sv */
// Port-level checks of the general configuration bank.
// Assumes it is bound to every instance of the bank.
`timescale 1ns/1ps
module dgc_general_config_chk
  import dgc_pkg::*;
#(
  parameter int ERR_WIDTH = 8
) (
  // Clock, reset and writes
  input wire logic                 i_sys_clk,
  input wire logic                 i_reset,
  input wire logic                 i_reg_wr,
  input wire dgc_pkg::dgc_byte_t   i_reg_addr,
  input wire dgc_pkg::dgc_byte_t   i_reg_wdata,
  // Steering and parity
  input wire logic                 i_txn_start,
  input wire logic                 i_txn_write,
  input wire logic                 o_fwd,
  input wire logic                 o_early_ack,
  input wire logic                 i_parity_err,
  input wire logic [ERR_WIDTH-1:0] o_parity_err_count,
  input wire logic                 o_parity_err_flag,
  // Configuration
  input wire logic                 o_ssc_enable,
  input wire logic [11:0]          o_ssc_divisor,
  input wire logic                 o_parity_check_en,
  input wire logic                 o_crc_gen_en,
  input wire logic                 o_io_supply_autodetect,
  input wire logic                 o_io_supply_level,
  input wire logic                 o_output_edge_select
);
  // ----------------
  // Shadow bits
  // ----------------
  // Pass-through, auto ack and parity reset have no port, so they are tracked here.
  logic [2:0] sh_reg;
  logic [2:0] sh_next;
  logic       wr02;
  logic       wr03;
  assign wr02 = i_reg_wr && i_reg_addr == 8'h02;
  assign wr03 = i_reg_wr && i_reg_addr == 8'h03;
  always_comb sh_next = wr03 ? i_reg_wdata[3:1] : sh_reg;
  always_ff @(posedge i_sys_clk) sh_reg <= i_reset ? 3'h4 : sh_next;
  // ----------------
  // Properties
  // ----------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  AST_SSC_OFF: assert property (wr02 && i_reg_wdata[3:0] == 4'h0 |-> ##2 !o_ssc_enable)
    else $error("modulation on after off code");
  AST_SSC_ON: assert property (wr02 && i_reg_wdata[3:0] != 4'h0 |->
    ##2 o_ssc_enable && o_ssc_divisor != 12'h000) else $error("modulation not on");
  AST_SSC_650: assert property (wr02 && i_reg_wdata[3:0] >= 4'hd |->
    ##2 o_ssc_divisor == 12'h28a) else $error("top codes not at divisor 650");
  AST_CFG_BITS: assert property (wr03 |=> ($past(i_reg_wdata) & 8'hf1) ==
    {o_parity_check_en, o_crc_gen_en, o_io_supply_autodetect, o_io_supply_level,
     3'h0, o_output_edge_select}) else $error("config bits do not follow write");
  AST_NO_FWD: assert property (i_txn_start && !sh_reg[2] |=> !o_fwd)
    else $error("forward with pass-through off");
  AST_EARLY_ACK: assert property (o_early_ack |-> $past(i_txn_start) &&
    $past(i_txn_write) && $past(sh_reg[1])) else $error("early ack without cause");
  AST_PAR_RST: assert property (wr03 && i_reg_wdata[1] |->
    ##2 o_parity_err_count == '0 && !o_parity_err_flag) else $error("parity state not reset");
  AST_PAR_OFF: assert property (!o_parity_check_en |-> o_parity_err_count == '0)
    else $error("count shown while checker off");
  AST_PAR_INC: assert property (i_parity_err && o_parity_check_en && !sh_reg[0] &&
    !i_reg_wr && !(&o_parity_err_count) |=> o_parity_err_flag &&
    o_parity_err_count == $past(o_parity_err_count) + 1'b1) else $error("error not counted");
  cover property (o_fwd && o_early_ack);
  cover property (o_ssc_divisor == 12'h28a);
  cover property (o_parity_err_flag ##1 !o_parity_err_flag);
endmodule
bind dgc_general_config dgc_general_config_chk #(.ERR_WIDTH(ERR_WIDTH)) u_chk (.*);

/* tb/dgc_general_config_tb.sv */
// Self-checking bench of the general configuration bank.
// Assumes the bank, its checker and the host model are compiled alongside.
`timescale 1ns/1ps
module dgc_general_config_tb;
  import dgc_pkg::*;
  localparam int EW = 4;
  logic i_sys_clk = 1'b0, i_reset = 1'b1, go = 1'b0, we = 1'b0;
  logic i_reg_wr, i_reg_rd, o_reg_rvalid, o_fwd, o_early_ack, o_parity_err_flag;
  logic i_txn_start = 1'b0, i_txn_write = 1'b0, i_slave_alias_hit = 1'b0;
  logic i_parity_err = 1'b0, o_ssc_enable, o_parity_check_en, o_crc_gen_en;
  logic o_io_supply_autodetect, o_io_supply_level, o_output_edge_select;
  logic [6:0] i_txn_addr = 7'h00, o_fwd_addr;
  logic [EW-1:0] o_parity_err_count;
  logic [11:0] o_ssc_divisor, divs [4] = '{12'h878, 12'h514, 12'h364, 12'h28a};
  logic [7:0] o_ssc_deviation, devs [4] = '{8'h32, 8'h64, 8'h96, 8'hc8};
  dgc_byte_t addr = 8'h00, wdata = 8'h00, i_reg_addr, i_reg_wdata, o_reg_rdata, v;
  dgc_byte_t rq[$], fq[$], ra [5] = '{8'h02, 8'h03, 8'h06, 8'h07, 8'h10};
  dgc_byte_t re [5] = '{8'h00, 8'he9, 8'h00, 8'h00, 8'h00};
  logic [15:0] seed = 16'h91a6;
  int bad_count = 0, n_compared = 0;
  wire [EW:0] pe = {o_parity_err_flag, o_parity_err_count};
  dgc_general_config #(.ERR_WIDTH(EW)) uut (.*);
  dgc_host_model host (.i_sys_clk(i_sys_clk), .i_go(go), .i_we(we), .i_addr(addr),
    .i_wdata(wdata), .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd), .o_reg_addr(i_reg_addr),
    .o_reg_wdata(i_reg_wdata));
  always #25 i_sys_clk = ~i_sys_clk;
  // ----------------
  // Helpers
  // ----------------
  function automatic dgc_byte_t rnd();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed[7:0];
  endfunction
  task automatic cmp(input logic [23:0] got, input logic [23:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // The fixed wait covers the two-write off-then-code sequence and its decode stage.
  task automatic acc(input logic w, input dgc_byte_t a, input dgc_byte_t d);
    @(posedge i_sys_clk);
    go <= 1'b1;
    we <= w;
    addr <= a;
    wdata <= d;
    @(posedge i_sys_clk);
    go <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic rd(input dgc_byte_t a, input dgc_byte_t e);
    rq.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask
  task automatic txn(input logic [6:0] a, input logic w, input logic hit);
    @(posedge i_sys_clk);
    i_txn_start <= 1'b1;
    i_txn_addr <= a;
    i_txn_write <= w;
    i_slave_alias_hit <= hit;
    @(posedge i_sys_clk);
    i_txn_start <= 1'b0;
    i_slave_alias_hit <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
  endtask
  task automatic perr(input int n);
    @(posedge i_sys_clk);
    i_parity_err <= 1'b1;
    repeat (n) @(posedge i_sys_clk);
    i_parity_err <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    #1;
  endtask
  always @(negedge i_sys_clk) begin
    if (o_reg_rvalid === 1'b1) cmp(o_reg_rdata, rq.size() ? rq.pop_front() : 8'hxx, "rd");
    if (o_fwd === 1'b1) cmp({o_early_ack, o_fwd_addr}, fq.size() ? fq.pop_front() : 8'hxx, "fwd");
  end
  initial begin
    repeat (4000) @(posedge i_sys_clk);
    bad_count++;
    close_out();
  end
  // ----------------
  // Scenarios
  // ----------------
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    #1;
    cmp({o_parity_check_en, o_crc_gen_en, o_io_supply_autodetect, o_io_supply_level,
      o_output_edge_select, o_ssc_enable, o_parity_err_flag, o_parity_err_count},
      {3'h7, 4'h4, 4'h0}, "reset outputs");
    foreach (ra[i]) rd(ra[i], re[i]);
    for (int c = 0; c < 16; c++) begin
      acc(1'b1, 8'h02, 8'(c));
      cmp({o_ssc_enable, o_ssc_divisor, c ? o_ssc_deviation : 8'h00},
        c ? {1'b1, divs[(c-1)/4], devs[(c-1)%4]} : 21'h0, "ssc");
    end
    rd(8'h02, 8'h0f);
    repeat (4) begin
      v = rnd();
      acc(1'b1, 8'h03, v);
      cmp({o_parity_check_en, o_crc_gen_en, o_io_supply_autodetect, o_io_supply_level,
        o_output_edge_select}, {v[7:4], v[0]}, "config bits");
      rd(8'h03, v);
    end
    acc(1'b1, 8'h06, 8'h54);
    acc(1'b1, 8'h07, 8'h62);
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 8'h03, {4'hc, i[1], i[0], 2'h0});
      if (i[1]) fq.push_back({i[0], 7'h2a});
      txn(7'h31, 1'b1, 1'b0);
      if (i[1]) fq.push_back({1'b0, 7'h44});
      txn(7'h44, 1'b0, 1'b1);
    end
    acc(1'b1, 8'h06, 8'h00);
    txn(7'h31, 1'b1, 1'b0);
    acc(1'b1, 8'h06, 8'h54);
    acc(1'b1, 8'h07, 8'h00);
    txn(7'h00, 1'b1, 1'b0);
    acc(1'b1, 8'h03, 8'he9);
    perr(20);
    cmp(pe, 5'h1f, "saturated count");
    acc(1'b1, 8'h03, 8'heb);
    perr(2);
    cmp(pe, 5'h00, "held in reset");
    acc(1'b1, 8'h03, 8'he9);
    perr(1);
    cmp(pe, 5'h11, "counting again");
    acc(1'b1, 8'h03, 8'h69);
    perr(2);
    cmp(pe, 5'h00, "checker off");
    acc(1'b1, 8'h03, 8'he9);
    cmp(pe, 5'h01, "count kept");
    cmp(rq.size() + fq.size(), 24'h0, "pending results");
    close_out();
  end
endmodule
